// >>> core/ceif_pkg.sv
/*
  constants for the error-state interrupt flag block: register offsets,
  flag bit positions, counter thresholds and reset values.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package ceif_pkg;
  localparam logic [7:0]  STATUS_OFS    = 8'h00;
  localparam logic [7:0]  MASK_OFS      = 8'h04;
  // flag positions within the 16-bit status word
  localparam int          OVL_BIT       = 15;
  localparam int          BUSOFF_BIT    = 14;
  localparam int          PASSIVE_BIT   = 13;
  localparam int          RXWARN_BIT    = 12;
  localparam int          TXWARN_BIT    = 11;
  localparam int          MODRST_BIT    = 8;
  localparam logic [15:0] FLAG_MASK     = 16'hf900;
  localparam logic [15:0] STATUS_INIT   = 16'h0100;
  localparam logic [15:0] MASK_INIT     = 16'hffff;
  localparam logic [8:0]  BUSOFF_LIMIT  = 9'h100;
  localparam logic [8:0]  PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0]  WARN_LIMIT    = 9'h060;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// >>> core/ceif_flags.sv
/*
  error-state and overload interrupt flags of a can controller, with an
  axi4-lite slave for the status and mask registers and one level irq.
  assumes the error counters and the overload event come from the can core
  on the same clock, so they are read without synchronisers.
*/
`default_nettype none
// Functional notes
// (RL1) bus-off flag sets while transmit error count is 256 or more
// (RL2) error-passive flag sets while either error count is 128 or more
// (RL3) receive warning flag sets while receive error count is 96 or more
// (RL4) overload flag, bit 15, sets on overload frame sent when not bus-off
// (RL5) error flags clear only by writing 1; writing 0 changes nothing
// (RL6) software reads a flag back after clearing it with irq enabled
// (RL7) status flags sit in bits 15..8; bit 8 resets to 1, others 0
// (RL8) transmit warning flag sets while transmit error count is 96 or more
// (RL9) module-reset flag sets after reset or standby exit; mask cannot hide it
// (RL10) a set in the same cycle as a write-1 clear wins
module ceif_flags (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [8:0]  transmit_error_count_i,
  input  wire logic [7:0]  receive_error_count_i,
  input  wire logic        overload_tx_i,
  input  wire logic        reset_done_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq_o
);
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] mask_r;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] wmask;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic        do_write;
  logic        busoff_now;
  logic        ovl_clr_hit;

  assign busoff_now = transmit_error_count_i >= ceif_pkg::BUSOFF_LIMIT;
  assign wmask      = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign do_write   = aw_held_r && w_held_r && !s_axi_bvalid;
  // write of 1 to the overload flag in this cycle, watched by the checks below
  assign ovl_clr_hit = do_write && awaddr_r == ceif_pkg::STATUS_OFS &&
                       wstrb_r[1] && wdata_r[ceif_pkg::OVL_BIT];

  always_comb begin
    set_vec = '0;
    set_vec[ceif_pkg::BUSOFF_BIT]  = busoff_now; // RL1
    set_vec[ceif_pkg::PASSIVE_BIT] = (transmit_error_count_i >= ceif_pkg::PASSIVE_LIMIT) ||
                                     ({1'b0, receive_error_count_i} >= ceif_pkg::PASSIVE_LIMIT); // RL2
    set_vec[ceif_pkg::RXWARN_BIT]  = {1'b0, receive_error_count_i} >= ceif_pkg::WARN_LIMIT; // RL3
    set_vec[ceif_pkg::TXWARN_BIT]  = transmit_error_count_i >= ceif_pkg::WARN_LIMIT; // RL8
    set_vec[ceif_pkg::OVL_BIT]     = overload_tx_i && !busoff_now; // RL4
    set_vec[ceif_pkg::MODRST_BIT]  = reset_done_i; // RL9
  end

  always_comb begin
    clr_vec = '0;
    if (do_write && awaddr_r == ceif_pkg::STATUS_OFS) begin
      clr_vec = wdata_r[15:0] & wmask & ceif_pkg::FLAG_MASK; // RL5
    end
    status_nxt = ((status_r & ~clr_vec) | set_vec) & ceif_pkg::FLAG_MASK; // RL10
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_r <= ceif_pkg::STATUS_INIT; // RL7
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_r <= ceif_pkg::MASK_INIT;
    end else if (do_write && awaddr_r == ceif_pkg::MASK_OFS) begin
      mask_r <= (mask_r & ~wmask) | (wdata_r[15:0] & wmask);
    end
  end

  // the module-reset flag bypasses the mask
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_r & ~mask_r) || status_r[ceif_pkg::MODRST_BIT]; // RL9
    end
  end

  // write channel: address and data taken in either order, then one response
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ceif_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == ceif_pkg::STATUS_OFS || awaddr_r == ceif_pkg::MASK_OFS)
                        ? ceif_pkg::RESP_OKAY : ceif_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= ceif_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= ceif_pkg::RESP_OKAY;
      if (s_axi_araddr == ceif_pkg::STATUS_OFS) begin
        s_axi_rdata <= {16'h0000, status_r}; // RL7
      end else if (s_axi_araddr == ceif_pkg::MASK_OFS) begin
        s_axi_rdata <= {16'h0000, mask_r};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= ceif_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence clear_ovl_s;
    ovl_clr_hit;
  endsequence

  chk_busoff_set: assert property ( // RL1
    transmit_error_count_i >= ceif_pkg::BUSOFF_LIMIT |=> status_r[ceif_pkg::BUSOFF_BIT])
    else $error("bus-off flag not set at count 256");
  chk_passive_set: assert property ( // RL2
    (transmit_error_count_i >= ceif_pkg::PASSIVE_LIMIT || receive_error_count_i[7])
    |=> status_r[ceif_pkg::PASSIVE_BIT])
    else $error("error-passive flag not set at count 128");
  chk_rx_warn_set: assert property ( // RL3
    {1'b0, receive_error_count_i} >= ceif_pkg::WARN_LIMIT |=> status_r[ceif_pkg::RXWARN_BIT])
    else $error("receive warning flag not set at count 96");
  chk_tx_warn_set: assert property ( // RL8
    transmit_error_count_i >= ceif_pkg::WARN_LIMIT |=> status_r[ceif_pkg::TXWARN_BIT])
    else $error("transmit warning flag not set at count 96");
  chk_overload_set: assert property ( // RL4
    overload_tx_i && transmit_error_count_i < ceif_pkg::BUSOFF_LIMIT
    |=> status_r[ceif_pkg::OVL_BIT] ##1 (irq_o || $past(mask_r[ceif_pkg::OVL_BIT])))
    else $error("overload flag or its irq not raised after overload frame");
  chk_flag_sticky: assert property ( // RL5
    status_r[ceif_pkg::OVL_BIT] && !ovl_clr_hit |=> status_r[ceif_pkg::OVL_BIT])
    else $error("overload flag dropped without write of 1");
  chk_write_clear: assert property ( // RL5
    clear_ovl_s ##0 !overload_tx_i |=> !status_r[ceif_pkg::OVL_BIT])
    else $error("write of 1 did not clear overload flag");
  chk_set_wins: assert property ( // RL10
    clear_ovl_s ##0 (overload_tx_i && !busoff_now) |=> status_r[ceif_pkg::OVL_BIT])
    else $error("clear beat a simultaneous overload set");
  chk_reset_unmask: assert property ( // RL9
    status_r[ceif_pkg::MODRST_BIT] |=> irq_o)
    else $error("module-reset flag did not raise irq");
  chk_low_bits_zero: assert property ( // RL7
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == ceif_pkg::STATUS_OFS
    |-> s_axi_rdata[7:0] == 8'h00 && s_axi_rdata[10:9] == 2'h0)
    else $error("unimplemented status bits read nonzero");
  chk_no_ovl_busoff: assert property ( // RL4
    busoff_now && !status_r[ceif_pkg::OVL_BIT] |=> !status_r[ceif_pkg::OVL_BIT])
    else $error("overload flag set while bus-off");
  chk_busoff_sticky: assert property ( // RL5
    status_r[ceif_pkg::BUSOFF_BIT] &&
    !(do_write && awaddr_r == ceif_pkg::STATUS_OFS && wdata_r[ceif_pkg::BUSOFF_BIT])
    |=> status_r[ceif_pkg::BUSOFF_BIT])
    else $error("bus-off flag dropped without write of 1");
endmodule
`default_nettype wire

// >>> test/ceif_can_model.sv
/*
  stand-in for the can core: error counts and overload pulse, registered.
  assumes the bench sets the wanted values one cycle ahead.
*/
`default_nettype none
module ceif_can_model (
  input  wire logic       clk_i,
  input  wire logic [8:0] tec_i,
  input  wire logic [7:0] rec_i,
  input  wire logic       ovl_i,
  output logic      [8:0] tec_o,
  output logic      [7:0] rec_o,
  output logic            ovl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) begin
    tec_o <= tec_i;
    rec_o <= rec_i;
    ovl_o <= ovl_i;
  end
endmodule
`default_nettype wire

// >>> test/tb_can_error_interrupt_flags.sv
/*
  self-checking bench for the error interrupt flags over axi4-lite.
  assumes the can model answers one cycle after its inputs change.
*/
`default_nettype none
module tb_can_error_interrupt_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, resetn_i = 0, rdn = 0, ovl = 0, mo, aw = 0, w = 0, b = 0, ar = 0, r = 0;
  logic awr, wr_r, bv, arr, rv, irq;
  logic [1:0] br, rr;
  logic [7:0] awa = 0, ara = 0, receive_error_count = 0, ro;
  logic [8:0] transmit_error_count = 0, to;
  logic [31:0] wd = 0, rd, got;
  int fail_count = 0, n_checks = 0, cyc = 0;
  ceif_can_model i_ceif_can_model (.clk_i(mclk_i), .tec_i(transmit_error_count), .rec_i(receive_error_count), .ovl_i(ovl),
    .tec_o(to), .rec_o(ro), .ovl_o(mo));
  ceif_flags i_ceif_flags (.mclk_i, .resetn_i, .transmit_error_count_i(to),
    .receive_error_count_i(ro), .overload_tx_i(mo), .reset_done_i(rdn),
    .s_axi_awaddr(awa), .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(w), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(b), .s_axi_araddr(ara), .s_axi_arvalid(ar),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(r), .irq_o(irq));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] eb = ceif_pkg::RESP_OKAY);
    awa <= a; wd <= d; aw <= 1; w <= 1; b <= 1;
    do begin
      @(posedge mclk_i);
      if (aw && awr) aw <= 0;
      if (w && wr_r) w <= 0;
      if (b && bv) b <= 0;
    end while (!(b && bv));
    chk("bresp", br, eb);
    // let an edge pass so the next request is not raised in this time step
    @(posedge mclk_i);
  endtask
  task automatic rdw(logic [7:0] a, logic [31:0] e, logic [1:0] er, string n);
    ara <= a; ar <= 1; r <= 1;
    do begin
      @(posedge mclk_i);
      if (ar && arr) ar <= 0;
    end while (!rv);
    r <= 0; got = rd;
    chk(n, got, e);
    chk("rresp", rr, er);
    @(posedge mclk_i);
  endtask
  task automatic settle(logic [8:0] t, logic [7:0] c);
    transmit_error_count <= t; receive_error_count <= c;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic t_reset;
    rdw(ceif_pkg::STATUS_OFS, 32'h0000_0100, ceif_pkg::RESP_OKAY, "status init");
    chk("irq bit8", irq, 1'b1);
    wr(ceif_pkg::STATUS_OFS, 32'h0000_0100);
    rdw(ceif_pkg::STATUS_OFS, 0, ceif_pkg::RESP_OKAY, "bit8 cleared");
    rdn <= 1; @(posedge mclk_i); rdn <= 0; @(posedge mclk_i); @(posedge mclk_i);
    rdw(ceif_pkg::STATUS_OFS, 32'h0000_0100, ceif_pkg::RESP_OKAY, "bit8 reset");
    wr(ceif_pkg::STATUS_OFS, 32'h0000_ffff);
    wr(ceif_pkg::MASK_OFS, 0);
    $display("test reset done");
  endtask
  task automatic t_levels;
    logic [8:0] tt[6] = '{9'h05f, 9'h060, 9'h000, 9'h080, 9'h000, 9'h100};
    logic [7:0] cc[6] = '{8'h00, 8'h00, 8'h60, 8'h00, 8'h80, 8'h00};
    logic [31:0] ee[6] = '{32'h0, 32'h0800, 32'h1000, 32'h2800, 32'h3000, 32'h6800};
    for (int i = 0; i < 6; i++) begin
      settle(tt[i], cc[i]);
      rdw(ceif_pkg::STATUS_OFS, ee[i], ceif_pkg::RESP_OKAY, "level flags");
      settle(0, 0);
      wr(ceif_pkg::STATUS_OFS, 32'h0000_ffff);
      rdw(ceif_pkg::STATUS_OFS, 0, ceif_pkg::RESP_OKAY, "w1c");
    end
    $display("test levels done");
  endtask
  task automatic t_overload;
    ovl <= 1; @(posedge mclk_i); ovl <= 0; repeat (3) @(posedge mclk_i);
    wr(ceif_pkg::STATUS_OFS, 32'h0000_0000);
    rdw(ceif_pkg::STATUS_OFS, 32'h8000, ceif_pkg::RESP_OKAY, "overload");
    chk("irq on", irq, 1'b1);
    wr(ceif_pkg::MASK_OFS, 32'h0000_ffff); @(posedge mclk_i);
    chk("irq masked", irq, 1'b0);
    settle(0, 8'h60);
    ovl <= 1;
    wr(ceif_pkg::STATUS_OFS, 32'h0000_ffff);
    ovl <= 0;
    rdw(ceif_pkg::STATUS_OFS, 32'h9000, ceif_pkg::RESP_OKAY, "set wins");
    wr(8'h08, 32'h0000_ffff, ceif_pkg::RESP_SLVERR);
    rdw(ceif_pkg::STATUS_OFS, 32'h9000, ceif_pkg::RESP_OKAY, "unmapped write");
    wr(ceif_pkg::STATUS_OFS, 32'h0000_ffff);
    rdw(ceif_pkg::STATUS_OFS, 32'h1000, ceif_pkg::RESP_OKAY, "overload w1c");
    rdw(8'h08, 0, ceif_pkg::RESP_SLVERR, "unmapped");
    settle(9'h100, 8'h00);
    ovl <= 1;
    @(posedge mclk_i);
    ovl <= 0;
    repeat (3) @(posedge mclk_i);
    rdw(ceif_pkg::STATUS_OFS, 32'h7800, ceif_pkg::RESP_OKAY, "no overload in bus-off");
    $display("test overload done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1;
    @(posedge mclk_i);
    t_reset();
    t_levels();
    t_overload();
    report_and_stop();
  end
endmodule
`default_nettype wire
